// *** rtl/scfe_engine.sv ***
// frame engine: receive blocks, ack/nak, run command, send response blocks
module scfe_engine import scfe_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// configuration
	input  wire logic        seven_bit,
	// uart receive byte stream
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	// uart transmit byte stream
	output logic             tx_valid,
	output logic      [7:0]  tx_data,
	input  wire logic        tx_ready,
	// command to the executor
	output logic             cmd_valid,
	output scfe_cmd_t        cmd,
	input  wire logic        cmd_done,
	input  wire scfe_res_t   res,
	// parameter bytes, shared buffer
	input  wire logic [BUF_AW-1:0] ex_addr,
	output logic      [7:0]  ex_rdata,
	input  wire logic        ex_we,
	input  wire logic [7:0]  ex_wdata,
	// status
	output logic             link_error,
	output logic             busy
);
	typedef enum {S_IDLE, S_NUM, S_MSG, S_LRC, S_REPLY, S_EXEC, S_TX, S_TXWAIT} scfe_state_t;

	scfe_state_t state_q, state_d;
	logic [1:0]  dig_q, dig_d;
	logic [3:0]  bnum_q, bnum_d;       // expected block number
	logic        num_bad_q, num_bad_d;
	logic [8:0]  mcnt_q, mcnt_d;       // bytes in this block
	logic [9:0]  plen_q, plen_d;       // parameter bytes stored
	logic [9:0]  pbase_q, pbase_d;     // parameter count at block start
	logic        lead_q, lead_d;       // lead char seen
	logic        func_ok_q, func_ok_d;
	logic        query_q, query_d;
	logic [7:0]  func_q, func_d;
	logic        last_q, last_d;       // etx seen
	logic [7:0]  reply_q, reply_d;
	logic [2:0]  retry_q, retry_d;
	logic        err_q, err_d;
	logic        cmdv_q, cmdv_d;
	scfe_res_t   res_q, res_d;
	logic [4:0]  tpos_q, tpos_d;       // transmit sequence position
	logic [9:0]  tidx_q, tidx_d;       // response payload index
	logic [1:0]  tblk_q, tblk_d;       // response block number
	logic [7:0]  txd_q, txd_d;
	logic        txv_q, txv_d;
	logic        rx_in_msg;
	logic        lrc_clear, lrc_add;
	logic [7:0]  lrc_val;
	logic        mem_we;
	logic [BUF_AW-1:0] mem_waddr, mem_raddr;
	logic [7:0]  mem_wdata, mem_rdata;

	// parameter buffer shared by receive and executor
	scfe_mem u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// one checksum unit, used for receive and transmit in turn
	scfe_lrc u_lrc (
		.clk       (clk),
		.rst       (rst),
		.clear     (lrc_clear),
		.add       (lrc_add),
		.data      (state_q == S_TX ? txd_q : rx_data),
		.seven_bit (seven_bit),
		.lrc       (lrc_val)
	);

	// parameter bytes land in the buffer; executor writes replies there after
	assign rx_in_msg = (state_q == S_MSG) && rx_valid && rx_data != CH_ETX && rx_data != CH_ETB;
	assign mem_we    = (rx_in_msg && func_ok_q) || ex_we;
	assign mem_waddr = ex_we ? ex_addr : plen_q[BUF_AW-1:0];
	assign mem_wdata = ex_we ? ex_wdata : rx_data;
	assign mem_raddr = (state_q == S_TX || state_q == S_TXWAIT) ? tidx_q[BUF_AW-1:0] : ex_addr;
	assign ex_rdata  = mem_rdata;

	assign tx_valid  = txv_q;
	assign tx_data   = txd_q;
	assign cmd_valid = cmdv_q;
	assign cmd       = '{query: query_q, func: func_q, len: plen_q};
	assign link_error = err_q;
	assign busy      = state_q != S_IDLE;

	// main sequencer
	always_comb begin
		state_d   = state_q;
		dig_d     = dig_q;
		bnum_d    = bnum_q;
		num_bad_d = num_bad_q;
		mcnt_d    = mcnt_q;
		plen_d    = plen_q;
		pbase_d   = pbase_q;
		lead_d    = lead_q;
		func_ok_d = func_ok_q;
		query_d   = query_q;
		func_d    = func_q;
		last_d    = last_q;
		reply_d   = reply_q;
		retry_d   = retry_q;
		err_d     = err_q;
		cmdv_d    = 1'b0;
		res_d     = res_q;
		tpos_d    = tpos_q;
		tidx_d    = tidx_q;
		tblk_d    = tblk_q;
		txd_d     = txd_q;
		txv_d     = txv_q;
		lrc_clear = 1'b0;
		lrc_add   = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (rx_valid && rx_data == CH_STX) begin
					state_d   = S_NUM;
					dig_d     = '0;
					num_bad_d = 1'b0;
					mcnt_d    = '0;
					pbase_d   = plen_q; // a nak on this block rolls back to here
					lrc_add   = 1'b1;
				end else begin
					lrc_clear = 1'b1;
				end
				if (rx_valid && rx_data == CH_STX && bnum_q == 4'd0) begin
					bnum_d    = 4'd1;
					plen_d    = '0;
					pbase_d   = '0;
					lead_d    = 1'b0;
					func_ok_d = 1'b0;
				end
			end
			S_NUM: if (rx_valid) begin
				lrc_add = 1'b1;
				dig_d   = dig_q + 2'd1;
				if (dig_q < NUM_DIGITS - 2'd1 && rx_data != CH_ZERO) num_bad_d = 1'b1;
				if (dig_q == NUM_DIGITS - 2'd1) begin
					if (rx_data != CH_ZERO + {4'h0, bnum_q}) num_bad_d = 1'b1;
					state_d = S_MSG;
				end
			end
			S_MSG: if (rx_valid) begin
				lrc_add = 1'b1;
				if (rx_data == CH_ETX || rx_data == CH_ETB) begin
					last_d  = rx_data == CH_ETX;
					state_d = S_LRC;
				end else begin
					mcnt_d = mcnt_q + 9'd1;
					if (mcnt_q == MSG_MAX_W) num_bad_d = 1'b1;
					if (bnum_q == 4'd1 && !lead_q) begin
						lead_d  = 1'b1;
						query_d = rx_data == CH_QUERY;
						if (rx_data != CH_SPACE && rx_data != CH_QUERY) num_bad_d = 1'b1;
					end else if (bnum_q == 4'd1 && !func_ok_q) begin
						func_ok_d = 1'b1;
						func_d    = rx_data;
					end else begin
						plen_d = plen_q + 10'd1; // bytes kept raw for the executor
					end
				end
			end
			S_LRC: if (rx_valid) begin
				state_d = S_REPLY;
				txv_d   = 1'b1;
				if (rx_data != lrc_val || num_bad_q) begin
					txd_d   = CH_NAK;
					reply_d = CH_NAK;
					plen_d  = pbase_q; // the resent block must not append twice
					if (bnum_q == 4'd1) begin
						lead_d    = 1'b0;
						func_ok_d = 1'b0;
					end
				end else begin
					txd_d   = CH_ACK;
					reply_d = CH_ACK;
				end
			end
			S_REPLY: if (tx_ready) begin
				txv_d = 1'b0;
				if (reply_q == CH_ACK && last_q) begin
					state_d = S_EXEC;
					cmdv_d  = 1'b1;
					bnum_d  = '0;
				end else begin
					if (reply_q == CH_ACK) bnum_d = bnum_q + 4'd1;
					state_d = S_IDLE;
				end
			end
			S_EXEC: if (cmd_done) begin
				res_d     = res;
				state_d   = S_TX;
				tpos_d    = '0;
				tidx_d    = '0;
				tblk_d    = 2'd1;
				retry_d   = '0;
				lrc_clear = 1'b1;
				txv_d     = 1'b0;
			end
			S_TX: begin
				// one byte per accepted beat; checksum takes it as it goes out
				if (!txv_q || tx_ready) begin
					if (txv_q) lrc_add = tpos_q != 5'd9;
					txv_d  = 1'b1;
					tpos_d = tpos_q + 5'd1;
					case (tpos_q)
						5'd0: txd_d = CH_STX;
						5'd1, 5'd2: txd_d = CH_ZERO;
						5'd3: txd_d = CH_ZERO + {6'h0, tblk_q};
						5'd4: begin
							if (tblk_q == 2'd1 && !res_q.fail) begin
								txd_d  = CH_HASH;
								tpos_d = 5'd8;
							end else if (tblk_q == 2'd1) begin
								txd_d = CH_BANG;
							end else begin
								txd_d  = mem_rdata;
								tidx_d = tidx_q + 10'd1;
								tpos_d = 5'd8;
							end
						end
						5'd5: txd_d = res_q.code[23:16];
						5'd6: txd_d = res_q.code[15:8];
						5'd7: txd_d = res_q.code[7:0];
						5'd8: begin
							if (tidx_q != res_q.len && !(tidx_q != '0 && tidx_q[7:0] == 8'd0 && tpos_q == 5'd8)) begin
								txd_d  = mem_rdata;
								tidx_d = tidx_q + 10'd1;
								tpos_d = 5'd8;
							end else begin
								txd_d  = (tidx_q == res_q.len) ? CH_ETX : CH_ETB;
								last_d = tidx_q == res_q.len;
							end
						end
						// end char goes out in this beat, so it is folded in here
						5'd9: txd_d = lrc_val ^ (seven_bit ? (txd_q & MSB_CLR) : txd_q);
						default: begin
							txv_d   = 1'b0;
							state_d = S_TXWAIT;
						end
					endcase
				end
			end
			S_TXWAIT: if (rx_valid) begin
				if (rx_data == CH_NAK) begin
					retry_d = retry_q + 3'd1;
					if (retry_q == RETRY_MAX - 3'd1) begin
						err_d   = 1'b1;
						state_d = S_IDLE;
					end else begin
						state_d   = S_TX;
						tpos_d    = '0;
						lrc_clear = 1'b1;
						tidx_d    = (tblk_q == 2'd1) ? 10'd0 : {1'b0, MSG_MAX_W};
					end
				end else if (rx_data == CH_ACK) begin
					retry_d = '0;
					if (last_q) begin
						state_d = S_IDLE;
					end else begin // second block only after ack
						state_d   = S_TX;
						tpos_d    = '0;
						tblk_d    = tblk_q + 2'd1;
						lrc_clear = 1'b1;
					end
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	// register stage
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= S_IDLE;
			dig_q     <= '0;
			bnum_q    <= '0;
			num_bad_q <= 1'b0;
			mcnt_q    <= '0;
			plen_q    <= '0;
			pbase_q   <= '0;
			lead_q    <= 1'b0;
			func_ok_q <= 1'b0;
			query_q   <= 1'b0;
			func_q    <= '0;
			last_q    <= 1'b0;
			reply_q   <= '0;
			retry_q   <= '0;
			err_q     <= 1'b0;
			cmdv_q    <= 1'b0;
			res_q     <= '0;
			tpos_q    <= '0;
			tidx_q    <= '0;
			tblk_q    <= '0;
			txd_q     <= '0;
			txv_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			dig_q     <= dig_d;
			bnum_q    <= bnum_d;
			num_bad_q <= num_bad_d;
			mcnt_q    <= mcnt_d;
			plen_q    <= plen_d;
			pbase_q   <= pbase_d;
			lead_q    <= lead_d;
			func_ok_q <= func_ok_d;
			query_q   <= query_d;
			func_q    <= func_d;
			last_q    <= last_d;
			reply_q   <= reply_d;
			retry_q   <= retry_d;
			err_q     <= err_d;
			cmdv_q    <= cmdv_d;
			res_q     <= res_d;
			tpos_q    <= tpos_d;
			tidx_q    <= tidx_d;
			tblk_q    <= tblk_d;
			txd_q     <= txd_d;
			txv_q     <= txv_d;
		end
	end
endmodule

// *** rtl/scfe_lrc.sv ***
// running xor checksum accumulator
module scfe_lrc import scfe_pkg::*; (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic       clear,
	input  wire logic       add,
	input  wire logic [7:0] data,
	input  wire logic       seven_bit,
	// result
	output logic      [7:0] lrc
);
	logic [7:0] acc_q;
	logic [7:0] acc_d;

	// clear reloads the all-ones seed
	always_comb begin
		acc_d = acc_q;
		if (clear) begin
			acc_d = LRC_INIT;
		end else if (add) begin
			acc_d = acc_q ^ data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_q <= LRC_INIT;
		end else begin
			acc_q <= acc_d;
		end
	end

	// seven-bit links cannot carry the top bit
	assign lrc = seven_bit ? (acc_q & MSB_CLR) : acc_q;
endmodule

// *** rtl/scfe_mem.sv ***
// small byte memory with registered read data
module scfe_mem import scfe_pkg::*; (
	// clock
	input  wire logic               clk,
	// write port
	input  wire logic               we,
	input  wire logic [BUF_AW-1:0]  waddr,
	input  wire logic [7:0]         wdata,
	// read port
	input  wire logic [BUF_AW-1:0]  raddr,
	output logic      [7:0]         rdata
);
	logic [7:0] mem [BUF_DEPTH];

	// registered read keeps the data output on a flop
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// *** rtl/scfe_pkg.sv ***
// constants, types and the behaviour list for the serial command frame engine
// Behaviour
// - control command leads with space, code, parameters
// - query command leads with question mark
// - parameters are hex ASCII of 16-bit values; the engine stores any byte raw and does not check this
// - lead and code only in first block
// - answer hash on success, bang plus code
// - send Ack or Nak per received block
// - execute after final Ack, then send response
// - device waits host Ack between response blocks
// - checksum starts FF, XOR start through end
// - seven-bit mode clears checksum top bit
// - bad checksum answered with Nak
// - resend on Nak, at most five attempts
// - block is start, number, message, end, checksum
// - start 02, final end 03, block end 17
// - Ack 06, Nak 15, hash 23, bang 21
package scfe_pkg;
	localparam logic [7:0] CH_STX   = 8'h02;
	localparam logic [7:0] CH_ETX   = 8'h03;
	localparam logic [7:0] CH_ETB   = 8'h17;
	localparam logic [7:0] CH_ACK   = 8'h06;
	localparam logic [7:0] CH_NAK   = 8'h15;
	localparam logic [7:0] CH_HASH  = 8'h23;
	localparam logic [7:0] CH_BANG  = 8'h21;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_QUERY = 8'h3F;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] LRC_INIT = 8'hFF;
	localparam logic [7:0] MSB_CLR  = 8'h7F;
	localparam int         MSG_MAX  = 255;
	localparam int         BUF_DEPTH = 512;
	localparam int         BUF_AW   = 9;
	localparam logic [2:0] RETRY_MAX = 3'd5;
	localparam logic [1:0] NUM_DIGITS = 2'd3;
	localparam logic [8:0] MSG_MAX_W = 9'd255;

	// one decoded command handed to the executor
	typedef struct packed {
		logic       query;
		logic [7:0] func;
		logic [9:0] len;
	} scfe_cmd_t;

	// executor result
	typedef struct packed {
		logic       fail;
		logic [23:0] code;
		logic [9:0] len;
	} scfe_res_t;
endpackage

// *** sim/scfe_engine_props.sv ***
// assertion checker for the frame engine ports
module scfe_engine_props import scfe_pkg::*; (
	// clock and reset
	input wire logic      clk,
	input wire logic      rst,
	// watched signals
	input wire logic      seven_bit,
	input wire logic      tx_valid,
	input wire logic[7:0] tx_data,
	input wire logic      tx_ready,
	input wire logic      cmd_valid,
	input wire scfe_cmd_t cmd,
	input wire logic      link_error,
	input wire logic      busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte changed before taken");
	AST_RST_QUIET: assert property ($fell(rst) |-> !tx_valid && !cmd_valid && !link_error)
		else $error("outputs active after reset");
	AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
		else $error("command pulse too long");
	AST_CMD_BUSY: assert property (cmd_valid |-> busy)
		else $error("command while idle");
	AST_LINK_STICKY: assert property (link_error |=> link_error)
		else $error("link error dropped");
	AST_TX_MSB: assert property (seven_bit && tx_valid |-> !tx_data[7])
		else $error("top bit set in seven bit mode");
	AST_TX_BUSY: assert property ($rose(tx_valid) |-> busy)
		else $error("transmit while idle");
	AST_CMD_LEN: assert property (cmd_valid |-> cmd.len <= 10'd509)
		else $error("command length too large");
	// main scenarios reached
	COV_CMD: cover property (cmd_valid && !cmd.query);
	COV_QRY: cover property (cmd_valid && cmd.query);
	COV_LINK: cover property ($rose(link_error));
endmodule
bind scfe_engine scfe_engine_props u_props (.clk(clk), .rst(rst), .seven_bit(seven_bit), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_ready(tx_ready), .cmd_valid(cmd_valid), .cmd(cmd), .link_error(link_error), .busy(busy));

// *** sim/scfe_engine_tb.sv ***
// self checking bench for the frame engine
module scfe_engine_tb;
	import scfe_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, sb = 0, rx_valid, tx_valid, tx_ready, cmd_valid, cmd_done = 0, link_error, busy;
	logic [7:0] rx_data, tx_data, ex_rdata, l;
	logic [BUF_AW-1:0] ex_addr = 0;
	logic ex_we = 0;
	logic [7:0] ex_wdata = 0;
	scfe_cmd_t cmd;
	scfe_res_t res = 0;
	int mismatches = 0, n_compared = 0;
	always #10 clk = ~clk;
	scfe_host u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready));
	scfe_engine u_dut (.clk(clk), .rst(rst), .seven_bit(sb), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_done(cmd_done), .res(res), .ex_addr(ex_addr), .ex_rdata(ex_rdata), .ex_we(ex_we),
		.ex_wdata(ex_wdata), .link_error(link_error), .busy(busy));
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task gb(output logic [7:0] b);
		logic ok;
		u_host.get(b, ok);
		if (!ok) begin
			mismatches++;
			$display("CHECK FAILED %0t no byte", $time);
			conclude();
		end
	endtask
	task snd(input logic [7:0] b);
		l ^= b;
		u_host.send(b);
	endtask
	// one host block, payload packed first byte highest
	task blk(input logic [31:0] pl, input int n, input logic bad, input logic [7:0] bn, input logic [7:0] ec);
		l = LRC_INIT;
		u_host.send(8'h41);
		snd(CH_STX);
		snd(CH_ZERO);
		snd(CH_ZERO);
		snd(bn);
		for (int i = n - 1; i >= 0; i--) snd(pl[8*i+:8]);
		snd(ec);
		u_host.send((sb ? l & MSB_CLR : l) ^ {7'h0, bad});
	endtask
	task eb(input logic [7:0] e);
		logic [7:0] g;
		gb(g);
		chk(g, e);
		l ^= e;
	endtask
	// expected response block built from the framing rules
	task resp(input logic [31:0] pl, input int n);
		l = LRC_INIT;
		eb(CH_STX);
		eb(CH_ZERO);
		eb(CH_ZERO);
		eb(8'h31);
		for (int i = n - 1; i >= 0; i--) eb(pl[8*i+:8]);
		eb(CH_ETX);
		eb(sb ? l & MSB_CLR : l);
	endtask
	task wc(input logic [18:0] e);
		int i;
		for (i = 0; i < 300 && cmd_valid !== 1'b1; i++) @(negedge clk);
		if (i == 300) begin
			mismatches++;
			$display("CHECK FAILED %0t no command", $time);
			conclude();
		end
		chk(cmd, e);
	endtask
	task done(input logic f, input logic [23:0] c, input logic [9:0] n);
		@(negedge clk);
		res = {f, c, n};
		cmd_done = 1;
		@(negedge clk);
		cmd_done = 0;
	endtask
	task t_ctrl(input logic s);
		logic [7:0] g;
		sb = s;
		blk(32'h0020_4131, 3, 0, 8'h31, CH_ETX);
		gb(g);
		chk(g, CH_ACK);
		wc({1'b0, 8'h41, 10'd1});
		ex_addr = 0;
		@(negedge clk);
		@(negedge clk);
		chk(ex_rdata, 8'h31);
		// executor leaves one reply byte after the hash
		@(negedge clk);
		ex_we    = 1;
		ex_wdata = 8'h35;
		@(negedge clk);
		ex_we    = 0;
		done(0, 24'h0, 10'd1);
		resp(32'h0000_2335, 2);
		u_host.send(CH_ACK);
		chk(busy, 0);
		$display("test ctrl done");
	endtask
	task t_query_fail;
		logic [7:0] g;
		sb = 0;
		blk(32'h3F42_3132, 4, 1, 8'h31, CH_ETX);
		gb(g);
		chk(g, CH_NAK);
		blk(32'h3F42_3132, 4, 0, 8'h31, CH_ETX);
		gb(g);
		chk(g, CH_ACK);
		wc({1'b1, 8'h42, 10'd2});
		done(1, 24'h45_3031, 10'd0);
		resp(32'h2145_3031, 4);
		u_host.send(CH_ACK);
		$display("test query fail done");
	endtask
	// two host blocks, the second sent only after the first is acked
	task t_two;
		logic [7:0] g;
		sb = 0;
		blk(32'h2044_3132, 4, 0, 8'h31, CH_ETB);
		gb(g);
		chk(g, CH_ACK);
		blk(32'h0000_3334, 2, 0, 8'h32, CH_ETX);
		gb(g);
		chk(g, CH_ACK);
		wc({1'b0, 8'h44, 10'd4});
		done(0, 24'h0, 10'd0);
		resp(CH_HASH, 1);
		u_host.send(CH_ACK);
		$display("test two block done");
	endtask
	// slow host refuses the response five times
	task t_retry;
		logic [7:0] g;
		u_host.stall = 3;
		blk(32'h0000_2043, 2, 0, 8'h31, CH_ETX);
		gb(g);
		chk(g, CH_ACK);
		wc({1'b0, 8'h43, 10'd0});
		done(0, 24'h0, 10'd0);
		for (int i = 0; i < 5; i++) begin
			resp(CH_HASH, 1);
			u_host.send(CH_NAK);
		end
		repeat (5) @(negedge clk);
		chk(link_error, 1);
		$display("test retry done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 0;
		t_ctrl(0);
		t_ctrl(1);
		t_query_fail();
		t_two();
		t_retry();
		conclude();
	end
endmodule

// *** sim/scfe_host.sv ***
// host side model: sends bytes, takes bytes with a stallable ready
module scfe_host (
	// clock
	input  wire logic      clk,
	// device receive stream
	output logic           rx_valid,
	output logic     [7:0] rx_data,
	// device transmit stream
	input  wire logic      tx_valid,
	input  wire logic[7:0] tx_data,
	output logic           tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int stall;
	// idle data shows the inverse so a stale byte never looks valid
	initial begin
		rx_valid = 0;
		rx_data  = 8'hFF;
		tx_ready = 0;
		stall    = 0;
	end
	task send(input logic [7:0] b);
		@(negedge clk);
		rx_valid = 1;
		rx_data  = b;
		@(negedge clk);
		rx_valid = 0;
		rx_data  = ~b;
	endtask
	// slow ready exercises the hold of tx data
	task get(output logic [7:0] b, output logic ok);
		int i;
		ok = 0;
		b  = 0;
		for (i = 0; i < 300 && !ok; i++) begin
			@(negedge clk);
			if (tx_valid === 1'b1) begin
				repeat (stall) @(negedge clk);
				tx_ready = 1;
				b = tx_data;
				@(negedge clk);
				tx_ready = 0;
				ok = 1;
			end
		end
	endtask
endmodule
